// ==== logic/codec_channel_rate_headset_cfg.sv ====
// Configuration register bank for channel limits, rate converter and detection.
// Assumes the serial control decoder delivers one-cycle write and read strobes.
//
// Behaviour
// - ADC force bit picks custom mask over select.
// - ADC custom mask bits 6-3, bit0 is channel1.
// - DAC force bit 7, mask bits 6-3.
// - Bit 7 enables the rate converter.
// - Bit 6 set turns autodetection off.
// - Manual bit chooses selected main rate.
// - Source bit picks primary or secondary port.
// - Numerator code zero infers, 5 and 7 reserved.
// - Denominator code zero infers, 5 and 7 reserved.
// - Pulse rate 0.5, 1, 7.5, 15 Hz.
// - Pulse high time 4 ms or 32 ms.
// - Tick period 1, 2, 4 ms; 3 reserved.
// - Hook threshold bit selects mic/hook limits.
// - Hook-pressed insert minimum 150, 100, 50 ohms.
// - Coupling bit: AC when clear, DC when set.
// - Current bit doubles headphone detection current.
// - Detection runs only while enable bit set.
// - Reserved bits read zero, writes ignored.
// - Insert debounce 16..512 ms, 7 disables.
// - Removal needs five or three detections.
// - Hook debounce none, two or three detections.
// - Headphone debounce none or three detections.
`timescale 1ns/1ps
`default_nettype none

module codec_channel_rate_headset_cfg
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire codec_cfg_pkg::reg_req_t req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic [3:0] adc_channel_limit_select,
  input wire logic [3:0] dac_channel_limit_select,
  output logic [3:0] adc_channel_enable,
  output logic [3:0] dac_channel_enable,
  output var codec_cfg_pkg::rate_cfg_t rate_cfg,
  output var codec_cfg_pkg::detect_cfg_t detect_cfg
);

  // ==========
  // Declarations.
  // ==========
  localparam int N = codec_cfg_pkg::REG_COUNT;

  logic [N-1:0][7:0] regs_q; // Register contents, indexed by register.
  logic [N-1:0][7:0] regs_d; // Next register contents.
  logic [N-1:0] hit; // Address match per register on the right page.
  logic page_ok; // Access targets this page.
  logic [7:0] rd_data_q; // Registered read answer.
  logic [7:0] rd_data_d; // Next read answer.
  logic rd_valid_q; // Read answer strobe.
  logic rd_valid_d; // Next read answer strobe.
  logic [3:0] adc_en_q; // Effective ADC channel enables.
  logic [3:0] adc_en_d; // Next ADC channel enables.
  logic [3:0] dac_en_q; // Effective DAC channel enables.
  logic [3:0] dac_en_d; // Next DAC channel enables.
  codec_cfg_pkg::rate_cfg_t rate_q; // Registered rate converter settings.
  codec_cfg_pkg::rate_cfg_t rate_d; // Next rate converter settings.
  codec_cfg_pkg::detect_cfg_t det_q; // Registered detection settings.
  codec_cfg_pkg::detect_cfg_t det_d; // Next detection settings.
  codec_cfg_pkg::ratio_term_t num_term; // Decoded numerator.
  codec_cfg_pkg::ratio_term_t den_term; // Decoded denominator.
  logic [7:0] src_ratio; // Alias of the ratio register.
  logic [7:0] det_time; // Alias of the detection timing register.
  logic [7:0] det_ctl; // Alias of the detection control register.
  logic [7:0] det_deb; // Alias of the detection debounce register.

  assign page_ok = (req.page == codec_cfg_pkg::CFG_PAGE);
  assign src_ratio = regs_q[codec_cfg_pkg::IDX_SRC_RATIO];
  assign det_time = regs_q[codec_cfg_pkg::IDX_DET_TIME];
  assign det_ctl = regs_q[codec_cfg_pkg::IDX_DET_CTL];
  assign det_deb = regs_q[codec_cfg_pkg::IDX_DET_DEB];

  // ==========
  // Register storage.
  // ==========
  // One slice per register: decode, masked write, and storage.
  for (genvar i = 0; i < N; i++)
  begin : g_reg
    // Reserved bits never take written data, so they always read as zero.
    always_comb
    begin
      hit[i] = page_ok && (req.addr == codec_cfg_pkg::REG_OFFSETS[i]);
      regs_d[i] = regs_q[i];
      if (req.wr && hit[i])
      begin
        regs_d[i] = req.wdata & codec_cfg_pkg::REG_WMASKS[i];
      end
    end

    // Registers hold while the clock enable is low.
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        regs_q[i] <= codec_cfg_pkg::REG_RESET;
      end
      else if (ce)
      begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ==========
  // Read path.
  // ==========
  // A read of an unmapped offset or another page answers zero.
  always_comb
  begin
    rd_data_d = rd_data_q;
    rd_valid_d = req.rd;
    if (req.rd)
    begin
      rd_data_d = 8'h00;
      for (int k = 0; k < N; k++)
      begin
        if (hit[k])
        begin
          rd_data_d = regs_q[k];
        end
      end
    end
  end

  // The read answer follows the strobe by one cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;

  // ==========
  // Ratio decoders.
  // ==========
  // Numerator term.
  ratio_term_decode u_num
  (
    .code (src_ratio[codec_cfg_pkg::RATIO_NUM_LSB +: 3]),
    .term (num_term)
  );

  // Denominator term.
  ratio_term_decode u_den
  (
    .code (src_ratio[codec_cfg_pkg::RATIO_DEN_LSB +: 3]),
    .term (den_term)
  );

  // ==========
  // Channel limits and rate converter.
  // ==========
  // The select inputs track the live mode; the force bit overrides them.
  always_comb
  begin
    adc_en_d = adc_channel_limit_select;
    if (regs_q[codec_cfg_pkg::IDX_ADC][codec_cfg_pkg::FORCE_BIT])
    begin
      adc_en_d = regs_q[codec_cfg_pkg::IDX_ADC][codec_cfg_pkg::MASK_LSB +: 4];
    end
    dac_en_d = dac_channel_limit_select;
    if (regs_q[codec_cfg_pkg::IDX_DAC][codec_cfg_pkg::FORCE_BIT])
    begin
      dac_en_d = regs_q[codec_cfg_pkg::IDX_DAC][codec_cfg_pkg::MASK_LSB +: 4];
    end
    rate_d.enable = regs_q[codec_cfg_pkg::IDX_SRC_CTL][codec_cfg_pkg::RC_ENABLE_BIT];
    rate_d.autodetect = !regs_q[codec_cfg_pkg::IDX_SRC_CTL][codec_cfg_pkg::RC_AUTO_OFF_BIT];
    rate_d.main_rate_inferred = !src_ratio[codec_cfg_pkg::MAIN_MANUAL_BIT];
    // The source bit only matters once the main rate is chosen by hand.
    rate_d.main_rate_secondary = src_ratio[codec_cfg_pkg::MAIN_MANUAL_BIT]
                                 && src_ratio[codec_cfg_pkg::MAIN_SOURCE_BIT];
    rate_d.numerator = num_term;
    rate_d.denominator = den_term;
  end

  // ==========
  // Detection settings.
  // ==========
  // Turns the detection fields into figures the detector uses directly.
  always_comb
  begin
    det_d.running = det_ctl[codec_cfg_pkg::DET_ENABLE_BIT];
    det_d.reserved_code = 1'b0;
    // Repetition rate, given as a period in microseconds.
    case (det_time[codec_cfg_pkg::PULSE_RATE_LSB +: 2])
      2'h0: det_d.pulse_period_us = codec_cfg_pkg::PULSE_PERIOD_US_0;
      2'h1: det_d.pulse_period_us = codec_cfg_pkg::PULSE_PERIOD_US_1;
      2'h2: det_d.pulse_period_us = codec_cfg_pkg::PULSE_PERIOD_US_2;
      default: det_d.pulse_period_us = codec_cfg_pkg::PULSE_PERIOD_US_3;
    endcase
    det_d.pulse_high_ms = det_time[codec_cfg_pkg::PULSE_HIGH_BIT]
                          ? codec_cfg_pkg::PULSE_HIGH_MS_LONG
                          : codec_cfg_pkg::PULSE_HIGH_MS_SHORT;
    // A reserved tick code falls back to the slowest period and is flagged.
    case (det_time[codec_cfg_pkg::TICK_LSB +: 2])
      2'h0: det_d.tick_ms = codec_cfg_pkg::TICK_MS_0;
      2'h1: det_d.tick_ms = codec_cfg_pkg::TICK_MS_1;
      2'h2: det_d.tick_ms = codec_cfg_pkg::TICK_MS_2;
      default:
      begin
        det_d.tick_ms = codec_cfg_pkg::TICK_MS_2;
        det_d.reserved_code = 1'b1;
      end
    endcase
    det_d.dc_coupled = det_ctl[codec_cfg_pkg::COUPLING_BIT];
    det_d.double_current = det_ctl[codec_cfg_pkg::DOUBLE_CUR_BIT];
    // Threshold pair; DC coupling changes the limit that is not traded.
    if (det_ctl[codec_cfg_pkg::HOOK_THR_BIT])
    begin
      det_d.hook_max_ohm = codec_cfg_pkg::HOOK_MAX_OHM_HIGH;
      det_d.mic_min_ohm = det_d.dc_coupled ? codec_cfg_pkg::MIC_MIN_OHM_DC
                                           : codec_cfg_pkg::MIC_MIN_OHM_HIGH;
    end
    else
    begin
      det_d.mic_min_ohm = codec_cfg_pkg::MIC_MIN_OHM_LOW;
      det_d.hook_max_ohm = det_d.dc_coupled ? codec_cfg_pkg::HOOK_MAX_OHM_DC
                                            : codec_cfg_pkg::HOOK_MAX_OHM_LOW;
    end
    case (det_ctl[codec_cfg_pkg::HOOK_INS_LSB +: 2])
      2'h0: det_d.hook_insert_min_ohm = codec_cfg_pkg::HOOK_INS_OHM_0;
      2'h1: det_d.hook_insert_min_ohm = codec_cfg_pkg::HOOK_INS_OHM_1;
      2'h2: det_d.hook_insert_min_ohm = codec_cfg_pkg::HOOK_INS_OHM_2;
      default:
      begin
        det_d.hook_insert_min_ohm = codec_cfg_pkg::HOOK_INS_OHM_2;
        det_d.reserved_code = 1'b1;
      end
    endcase
    // Insert debounce doubles from 16 ms; code 7 means none at all.
    det_d.insert_debounce_off = 1'b0;
    case (det_deb[codec_cfg_pkg::INSERT_DEB_LSB +: 3])
      codec_cfg_pkg::INSERT_DEB_NONE:
      begin
        det_d.insert_debounce_ms = 10'd0;
        det_d.insert_debounce_off = 1'b1;
      end
      codec_cfg_pkg::INSERT_DEB_RESERVED:
      begin
        det_d.insert_debounce_ms = 10'd0;
        det_d.insert_debounce_off = 1'b1;
        det_d.reserved_code = 1'b1;
      end
      default:
      begin
        det_d.insert_debounce_ms = codec_cfg_pkg::INSERT_DEB_MS_BASE
                                   << det_deb[codec_cfg_pkg::INSERT_DEB_LSB +: 3];
      end
    endcase
    det_d.removal_count = det_deb[codec_cfg_pkg::REMOVAL_DEB_BIT]
                          ? codec_cfg_pkg::REMOVAL_COUNT_1
                          : codec_cfg_pkg::REMOVAL_COUNT_0;
    case (det_deb[codec_cfg_pkg::HOOK_DEB_LSB +: 2])
      2'h2: det_d.hook_count = codec_cfg_pkg::COUNT_TWO;
      2'h3: det_d.hook_count = codec_cfg_pkg::COUNT_THREE;
      default: det_d.hook_count = codec_cfg_pkg::COUNT_NONE;
    endcase
    det_d.phone_count = det_deb[codec_cfg_pkg::PHONE_DEB_BIT]
                        ? codec_cfg_pkg::COUNT_THREE
                        : codec_cfg_pkg::COUNT_NONE;
    // Reserved ratio codes are surfaced here too so one flag covers all.
    if (num_term.reserved || den_term.reserved)
    begin
      det_d.reserved_code = 1'b1;
    end
  end

  // ==========
  // Output registers.
  // ==========
  // Registered so that consumers see settings change on one clean edge.
  // The rate and detection reset image matches what all-zero registers decode to; the channel enables reset to zero, not to the selects.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      adc_en_q <= 4'h0;
      dac_en_q <= 4'h0;
      rate_q <= '{enable: 1'b0, autodetect: 1'b1, main_rate_inferred: 1'b1,
                  main_rate_secondary: 1'b0,
                  numerator: '{inferred: 1'b1, reserved: 1'b0, value: 3'h0},
                  denominator: '{inferred: 1'b1, reserved: 1'b0, value: 3'h0}};
      det_q <= '{running: 1'b0,
                 pulse_period_us: codec_cfg_pkg::PULSE_PERIOD_US_0,
                 pulse_high_ms: codec_cfg_pkg::PULSE_HIGH_MS_SHORT,
                 tick_ms: codec_cfg_pkg::TICK_MS_0,
                 mic_min_ohm: codec_cfg_pkg::MIC_MIN_OHM_LOW,
                 hook_max_ohm: codec_cfg_pkg::HOOK_MAX_OHM_LOW,
                 hook_insert_min_ohm: codec_cfg_pkg::HOOK_INS_OHM_0,
                 dc_coupled: 1'b0, double_current: 1'b0,
                 insert_debounce_ms: codec_cfg_pkg::INSERT_DEB_MS_BASE,
                 insert_debounce_off: 1'b0,
                 removal_count: codec_cfg_pkg::REMOVAL_COUNT_0,
                 hook_count: codec_cfg_pkg::COUNT_NONE,
                 phone_count: codec_cfg_pkg::COUNT_NONE,
                 reserved_code: 1'b0};
    end
    else if (ce)
    begin
      adc_en_q <= adc_en_d;
      dac_en_q <= dac_en_d;
      rate_q <= rate_d;
      det_q <= det_d;
    end
  end

  assign adc_channel_enable = adc_en_q;
  assign dac_channel_enable = dac_en_q;
  assign rate_cfg = rate_q;
  assign detect_cfg = det_q;

endmodule : codec_channel_rate_headset_cfg
`default_nettype wire

// ==== logic/codec_cfg_pkg.sv ====
// Shared constants and carrier types for the codec configuration page.
// Assumes one clock and an asynchronous active-low reset.
package codec_cfg_pkg;

  // ==========
  // Register map of the configuration page.
  // ==========
  localparam logic [7:0] CFG_PAGE = 8'h01; // Page that holds these registers.
  localparam int REG_COUNT = 7; // Number of registers in the bank.
  localparam logic [7:0] ADC_DYNAMIC_CHANNEL_LIMIT = 8'h0e;
  localparam logic [7:0] DAC_DYNAMIC_CHANNEL_LIMIT = 8'h0f;
  localparam logic [7:0] RATE_CONVERTER_CONTROL = 8'h17;
  localparam logic [7:0] RATE_CONVERTER_RATIO = 8'h18;
  localparam logic [7:0] HEADSET_DETECT_TIMING = 8'h19;
  localparam logic [7:0] HEADSET_DETECT_CONTROL = 8'h1a;
  localparam logic [7:0] HEADSET_DETECT_DEBOUNCE = 8'h1b;
  localparam logic [REG_COUNT-1:0][7:0] REG_OFFSETS = {
    HEADSET_DETECT_DEBOUNCE, HEADSET_DETECT_CONTROL, HEADSET_DETECT_TIMING,
    RATE_CONVERTER_RATIO, RATE_CONVERTER_CONTROL, DAC_DYNAMIC_CHANNEL_LIMIT,
    ADC_DYNAMIC_CHANNEL_LIMIT};
  // Writable bits per register; reserved bits stay zero.
  localparam logic [REG_COUNT-1:0][7:0] REG_WMASKS = {
    8'h7f, 8'h7e, 8'he6, 8'hff, 8'hc0, 8'hf8, 8'hf8};
  localparam logic [7:0] REG_RESET = 8'h00; // Every register resets to zero.

  // Register indices.
  localparam int IDX_ADC = 0;
  localparam int IDX_DAC = 1;
  localparam int IDX_SRC_CTL = 2;
  localparam int IDX_SRC_RATIO = 3;
  localparam int IDX_DET_TIME = 4;
  localparam int IDX_DET_CTL = 5;
  localparam int IDX_DET_DEB = 6;

  // ==========
  // Field positions.
  // ==========
  localparam int FORCE_BIT = 7;
  localparam int MASK_LSB = 3;
  localparam int RC_ENABLE_BIT = 7;
  localparam int RC_AUTO_OFF_BIT = 6;
  localparam int MAIN_MANUAL_BIT = 7;
  localparam int MAIN_SOURCE_BIT = 6;
  localparam int RATIO_NUM_LSB = 3;
  localparam int RATIO_DEN_LSB = 0;
  localparam int PULSE_RATE_LSB = 6;
  localparam int PULSE_HIGH_BIT = 5;
  localparam int TICK_LSB = 1;
  localparam int HOOK_THR_BIT = 6;
  localparam int HOOK_INS_LSB = 4;
  localparam int COUPLING_BIT = 3;
  localparam int DOUBLE_CUR_BIT = 2;
  localparam int DET_ENABLE_BIT = 1;
  localparam int PHONE_DEB_BIT = 6;
  localparam int INSERT_DEB_LSB = 3;
  localparam int REMOVAL_DEB_BIT = 2;
  localparam int HOOK_DEB_LSB = 0;

  // ==========
  // Decoded timing and threshold figures.
  // ==========
  localparam logic [20:0] PULSE_PERIOD_US_0 = 21'd2000000; // 0.5 Hz.
  localparam logic [20:0] PULSE_PERIOD_US_1 = 21'd1000000; // 1 Hz.
  localparam logic [20:0] PULSE_PERIOD_US_2 = 21'd133333; // 7.5 Hz.
  localparam logic [20:0] PULSE_PERIOD_US_3 = 21'd66667; // 15 Hz.
  localparam logic [5:0] PULSE_HIGH_MS_SHORT = 6'd4;
  localparam logic [5:0] PULSE_HIGH_MS_LONG = 6'd32;
  localparam logic [2:0] TICK_MS_0 = 3'd1;
  localparam logic [2:0] TICK_MS_1 = 3'd2;
  localparam logic [2:0] TICK_MS_2 = 3'd4;
  localparam logic [10:0] MIC_MIN_OHM_LOW = 11'd800;
  localparam logic [10:0] MIC_MIN_OHM_HIGH = 11'd1350;
  localparam logic [10:0] MIC_MIN_OHM_DC = 11'd1750;
  localparam logic [10:0] HOOK_MAX_OHM_LOW = 11'd320;
  localparam logic [10:0] HOOK_MAX_OHM_HIGH = 11'd680;
  localparam logic [10:0] HOOK_MAX_OHM_DC = 11'd150;
  localparam logic [7:0] HOOK_INS_OHM_0 = 8'd150;
  localparam logic [7:0] HOOK_INS_OHM_1 = 8'd100;
  localparam logic [7:0] HOOK_INS_OHM_2 = 8'd50;
  localparam logic [9:0] INSERT_DEB_MS_BASE = 10'd16; // Doubles per code step.
  localparam logic [2:0] INSERT_DEB_RESERVED = 3'd6;
  localparam logic [2:0] INSERT_DEB_NONE = 3'd7;
  localparam logic [2:0] REMOVAL_COUNT_0 = 3'd5;
  localparam logic [2:0] REMOVAL_COUNT_1 = 3'd3;
  localparam logic [2:0] COUNT_NONE = 3'd1; // One detection, no debounce.
  localparam logic [2:0] COUNT_TWO = 3'd2;
  localparam logic [2:0] COUNT_THREE = 3'd3;

  // ==========
  // Carrier types.
  // ==========
  // Register access from the serial control decoder.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Decoded ratio term of the rate converter.
  typedef struct packed {
    logic inferred;
    logic reserved;
    logic [2:0] value;
  } ratio_term_t;

  // Rate converter settings seen by the datapath.
  typedef struct packed {
    logic enable;
    logic autodetect;
    logic main_rate_inferred;
    logic main_rate_secondary;
    ratio_term_t numerator;
    ratio_term_t denominator;
  } rate_cfg_t;

  // Headset and headphone detection settings seen by the detector.
  typedef struct packed {
    logic running;
    logic [20:0] pulse_period_us;
    logic [5:0] pulse_high_ms;
    logic [2:0] tick_ms;
    logic [10:0] mic_min_ohm;
    logic [10:0] hook_max_ohm;
    logic [7:0] hook_insert_min_ohm;
    logic dc_coupled;
    logic double_current;
    logic [9:0] insert_debounce_ms;
    logic insert_debounce_off;
    logic [2:0] removal_count;
    logic [2:0] hook_count;
    logic [2:0] phone_count;
    logic reserved_code;
  } detect_cfg_t;

endpackage : codec_cfg_pkg

// ==== logic/ratio_term_decode.sv ====
// Decoder for one three-bit ratio term of the rate converter.
// Assumes the code comes straight from a register bit field.
`timescale 1ns/1ps
`default_nettype none

module ratio_term_decode
(
  input wire logic [2:0] code,
  output var codec_cfg_pkg::ratio_term_t term
);

  // ==========================================================================
  // Decode.
  // ==========================================================================
  // Zero asks for inference, codes 5 and 7 are reserved, the rest are literal.
  always_comb
  begin
    term.inferred = (code == 3'h0);
    term.reserved = (code == 3'h5) || (code == 3'h7);
    // A reserved code is reported as value zero so nobody divides by junk.
    term.value = term.reserved ? 3'h0 : code;
  end

endmodule : ratio_term_decode
`default_nettype wire

// ==== tb/cfg_bank_chk.sv ====
// Port checker for the configuration bank.
// Assumes it is bound to the bank top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Checker
// ==========================================================================
module cfg_bank_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire codec_cfg_pkg::reg_req_t req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [3:0] adc_channel_limit_select,
  input wire logic [3:0] dac_channel_limit_select,
  input wire logic [3:0] adc_channel_enable,
  input wire logic [3:0] dac_channel_enable,
  input wire codec_cfg_pkg::rate_cfg_t rate_cfg,
  input wire codec_cfg_pkg::detect_cfg_t detect_cfg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // A write taken on this page at one offset.
  sequence s_wr(logic [7:0] a);
    ce && req.wr && req.page == 8'h01 && req.addr == a;
  endsequence
  // The write, one edge into the register, one edge into the outputs.
  sequence s_set(logic [7:0] a);
    s_wr(a) ##1 ce ##1 1'b1;
  endsequence
  a_foreign_page: assert property (ce && req.rd && req.page != 8'h01 |=> rd_valid && rd_data == 8'h00)
    else $error("foreign page read not refused");
  a_adc_reserved: assert property (rd_valid && $past(req.addr) == 8'h0e |-> rd_data[2:0] == 3'h0)
    else $error("reserved adc bits read nonzero");
  a_adc_custom: assert property (s_set(8'h0e) |-> !$past(req.wdata[7], 2) ||
    adc_channel_enable == $past(req.wdata[6:3], 2)) else $error("adc custom mask not used");
  a_dac_select: assert property (s_set(8'h0f) |-> $past(req.wdata[7], 2) ||
    dac_channel_enable == $past(dac_channel_limit_select)) else $error("dac select not used");
  a_conv_enable: assert property (s_set(8'h17) |-> rate_cfg.enable == $past(req.wdata[7], 2) &&
    rate_cfg.autodetect == !$past(req.wdata[6], 2)) else $error("converter control wrong");
  a_main_manual: assert property (s_set(8'h18) |-> rate_cfg.main_rate_inferred == !$past(req.wdata[7], 2))
    else $error("main rate manual wrong");
  a_ratio_reserved: assert property (s_set(8'h18) |-> rate_cfg.numerator.reserved ==
    ($past(req.wdata[5:3], 2) inside {3'd5, 3'd7})) else $error("numerator reserved flag wrong");
  a_pulse_high: assert property (s_set(8'h19) |-> detect_cfg.pulse_high_ms == ($past(req.wdata[5], 2) ? 6'd32 : 6'd4))
    else $error("pulse high time wrong");
  a_detect_run: assert property (s_set(8'h1a) |-> detect_cfg.running == $past(req.wdata[1], 2))
    else $error("detect enable wrong");
  a_removal_count: assert property (s_set(8'h1b) |-> detect_cfg.removal_count == ($past(req.wdata[2], 2) ? 3'd3 : 3'd5))
    else $error("removal count wrong");
endmodule : cfg_bank_chk
bind codec_channel_rate_headset_cfg cfg_bank_chk cfg_bank_chk_i (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
  .rd_data(rd_data), .rd_valid(rd_valid), .adc_channel_limit_select(adc_channel_limit_select),
  .dac_channel_limit_select(dac_channel_limit_select), .adc_channel_enable(adc_channel_enable),
  .dac_channel_enable(dac_channel_enable), .rate_cfg(rate_cfg), .detect_cfg(detect_cfg));
`default_nettype wire

// ==== tb/cfg_host.sv ====
// Host model driving single-byte register accesses.
// Assumes one clock; the caller waits on the access task.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Host
// ==========================================================================
module cfg_host
(
  input wire logic clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output var codec_cfg_pkg::reg_req_t req
);
  // The bus is idle at time zero.
  initial
  begin
    req = '0;
  end
  // Callers may pass reserved bits and codes; the data is driven unchanged.
  task automatic acc(input logic w, input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic v);
    @(posedge clk);
    #1;
    req = '{wr: w, rd: !w, page: pg, addr: a, wdata: d};
    @(posedge clk);
    #1;
    q = rd_data;
    v = rd_valid;
    // Released fields show the inverse so a stale value cannot pass.
    req = '{wr: 1'b0, rd: 1'b0, page: ~pg, addr: ~a, wdata: ~d};
  endtask : acc
endmodule : cfg_host
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the configuration bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] asel = 4'h0;
  logic [3:0] dsel = 4'h0;
  codec_cfg_pkg::reg_req_t req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [3:0] aen;
  logic [3:0] den;
  codec_cfg_pkg::rate_cfg_t rate_cfg;
  codec_cfg_pkg::detect_cfg_t detect_cfg;
  int fail_count = 0;
  int check_count = 0;
  int seed = 32'hc200;
  logic [7:0] sh [7]; // Shadow of what each register should hold.
  always #12.5 clk = ~clk;
  cfg_host cfg_host_i (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));
  codec_channel_rate_headset_cfg codec_channel_rate_headset_cfg_i (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .adc_channel_limit_select(asel), .dac_channel_limit_select(dsel),
    .adc_channel_enable(aen), .dac_channel_enable(den), .rate_cfg(rate_cfg), .detect_cfg(detect_cfg));
  // ========================================================================
  // Expectations
  // ========================================================================
  function automatic codec_cfg_pkg::ratio_term_t term(input logic [2:0] c);
    logic r;
    r = (c == 3'd5) || (c == 3'd7);
    return '{inferred: c == 3'd0, reserved: r, value: r ? 3'd0 : c};
  endfunction : term
  function automatic codec_cfg_pkg::rate_cfg_t exp_rate();
    return '{enable: sh[2][7], autodetect: !sh[2][6], main_rate_inferred: !sh[3][7],
      main_rate_secondary: sh[3][7] & sh[3][6], numerator: term(sh[3][5:3]), denominator: term(sh[3][2:0])};
  endfunction : exp_rate
  function automatic codec_cfg_pkg::detect_cfg_t exp_det();
    codec_cfg_pkg::detect_cfg_t e;
    logic [20:0] per [4] = '{21'd2000000, 21'd1000000, 21'd133333, 21'd66667};
    e.running = sh[5][1];
    e.pulse_period_us = per[sh[4][7:6]];
    e.pulse_high_ms = sh[4][5] ? 6'd32 : 6'd4;
    e.tick_ms = (sh[4][2:1] == 2'd0) ? 3'd1 : (sh[4][2:1] == 2'd1) ? 3'd2 : 3'd4;
    e.mic_min_ohm = !sh[5][6] ? 11'd800 : sh[5][3] ? 11'd1750 : 11'd1350;
    e.hook_max_ohm = sh[5][6] ? 11'd680 : sh[5][3] ? 11'd150 : 11'd320;
    e.hook_insert_min_ohm = (sh[5][5:4] == 2'd0) ? 8'd150 : (sh[5][5:4] == 2'd1) ? 8'd100 : 8'd50;
    e.dc_coupled = sh[5][3];
    e.double_current = sh[5][2];
    e.insert_debounce_ms = 10'd16 << sh[6][5:3];
    e.insert_debounce_off = 1'b0;
    e.removal_count = sh[6][2] ? 3'd3 : 3'd5;
    e.hook_count = (sh[6][1:0] < 2'd2) ? 3'd1 : {1'b0, sh[6][1:0]};
    e.phone_count = sh[6][6] ? 3'd3 : 3'd1;
    e.reserved_code = (sh[4][2:1] == 2'd3) || (sh[5][5:4] == 2'd3) || (sh[3][5:3] inside {3'd5, 3'd7}) ||
      (sh[3][2:0] inside {3'd5, 3'd7});
    return e;
  endfunction : exp_det
  task automatic check(input string name, input logic [83:0] seen, input logic [83:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ========================================================================
  // Tests
  // ========================================================================
  initial
  begin
    logic [7:0] q;
    logic v;
    logic [7:0] d;
    int i;
    codec_cfg_pkg::detect_cfg_t e;
    for (i = 0; i < 7; i++) sh[i] = 8'h00;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    check("reset rate", rate_cfg, exp_rate());
    check("reset detect", detect_cfg, exp_det());
    // The first seven writes are all ones except bit 4 of the debounce register, the rest random; reserved bits must read back zero.
    for (int n = 0; n < 70; n++)
    begin
      i = (n < 7) ? n : $unsigned($random(seed)) % 7;
      d = (n < 7) ? 8'hff : $random(seed);
      if (i == 6 && d[5:4] == 2'b11) d[4] = 1'b0;
      asel = $random(seed);
      dsel = $random(seed);
      cfg_host_i.acc(1'b1, 8'h01, codec_cfg_pkg::REG_OFFSETS[i], d, q, v);
      sh[i] = d & codec_cfg_pkg::REG_WMASKS[i];
      cfg_host_i.acc(1'b0, 8'h01, codec_cfg_pkg::REG_OFFSETS[i], 8'h00, q, v);
      e = exp_det();
      check("read back", {v, q}, {1'b1, sh[i]});
      check("adc enable", aen, sh[0][7] ? sh[0][6:3] : asel);
      check("dac enable", den, sh[1][7] ? sh[1][6:3] : dsel);
      check("rate", rate_cfg, exp_rate());
      check("detect", detect_cfg, e);
      check("debounce", {detect_cfg.running, detect_cfg[20:1]}, {e.running, e[20:1]});
    end
    $display("test random done");
    // Foreign page and unmapped offset are refused.
    cfg_host_i.acc(1'b1, 8'h00, 8'h18, ~sh[3], q, v);
    cfg_host_i.acc(1'b0, 8'h00, 8'h18, 8'h00, q, v);
    check("foreign read", {v, q}, 9'h100);
    cfg_host_i.acc(1'b0, 8'h01, 8'h1c, 8'h00, q, v);
    check("unmapped read", {v, q}, 9'h100);
    // A write while the clock enable is low is not taken.
    ce = 1'b0;
    cfg_host_i.acc(1'b1, 8'h01, 8'h18, ~sh[3], q, v);
    ce = 1'b1;
    cfg_host_i.acc(1'b0, 8'h01, 8'h18, 8'h00, q, v);
    check("kept ratio", {v, q}, {1'b1, sh[3]});
    $display("test refused done");
    // The last insertion code turns debounce off.
    cfg_host_i.acc(1'b1, 8'h01, 8'h1b, 8'h38, q, v);
    cfg_host_i.acc(1'b0, 8'h01, 8'h1b, 8'h00, q, v);
    check("debounce off", detect_cfg.insert_debounce_off, 1'b1);
    $display("test debounce off done");
    final_report();
  end
  // A hang is cut short well beyond the expected run.
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
